/* rtl/dmp_pkg.sv */
// Constants, register map and carrier types for the channel B modem pins.
package dmp_pkg;

   // ==========================================================
   // Bus widths.
   localparam int DMP_ADDR_W = 4;
   localparam int DMP_DATA_W = 8;

   // ==========================================================
   // Register offsets.
   localparam logic [3:0] OFS_INT_ENABLE    = 4'h1;
   localparam logic [3:0] OFS_ALT_FUNCTION  = 4'h2;
   localparam logic [3:0] OFS_ENH_FEATURE   = 4'h3;
   localparam logic [3:0] OFS_MODEM_CONTROL = 4'h4;
   localparam logic [3:0] OFS_FEAT_CONTROL  = 4'h5;
   localparam logic [3:0] OFS_EXT_MODE      = 4'h6;
   localparam logic [3:0] OFS_MODEM_LEVELS  = 4'h7;
   localparam logic [3:0] OFS_EVENT_STATUS  = 4'h8;
   localparam logic [3:0] OFS_EVENT_MASK    = 4'h9;

   // ==========================================================
   // Field positions.
   localparam int MC_TERM_READY_BIT = 0;
   localparam int MC_REQ_SEND_BIT   = 1;
   localparam int MC_USER_OUT2_BIT  = 3;
   localparam int AF_SEL_LSB        = 1;
   localparam int AF_SEL_MSB        = 2;
   localparam int EF_AUTO_RTS_BIT   = 6;
   localparam int EF_AUTO_CTS_BIT   = 7;
   localparam int IE_CTS_BIT        = 7;
   localparam int FC_DIR_CTRL_BIT   = 3;
   localparam int EM_DIR_INVERT_BIT = 3;

   // ==========================================================
   // Reset values.
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] EVT_RESET = 4'h0;

   // ==========================================================
   // Alternate function field codes.
   localparam logic [1:0] AF_CODE_USER  = 2'h0;
   localparam logic [1:0] AF_CODE_BAUD  = 2'h1;
   localparam logic [1:0] AF_CODE_RXRDY = 2'h2;

   // Decoded multi-function selection, one-hot.
   typedef enum logic [2:0] {
      MF_USER  = 3'h1,
      MF_BAUD  = 3'h2,
      MF_RXRDY = 3'h4
   } dmp_mf_sel_type;

   // Modem inputs in active-high form; also the event bit order.
   typedef struct packed {
      logic cts;
      logic dsr;
      logic cd;
      logic ri;
   } dmp_modem_in_type;

endpackage : dmp_pkg

/* rtl/dmp_modem_pins.sv */
// Channel B modem-control and multi-function output pin logic.
//
// Functional notes
// - Request-to-send pin is active low; handshake output or software output.
// - Active-low clear-to-send gates auto CTS transmit; event enable bit.
// - Request-to-send pin doubles as RS-485 direction when direction bit set.
// - Active-low terminal-ready output, usable as a general output.
// - Set-ready, carrier-detect, ring inputs readable and logged as events; no UART effect.
// - Multi-function pin shows one of three functions, chosen by bits 2:1.
// - User-output function drives the pin low while control bit 3 is set.
// - Modem-control bit 3 clears to zero on reset.
// - Baud-clock function puts the 16x baud clock on the pin.
// - Receive-ready function puts active-low receive-ready on the pin.
// - Direction mode, invert bit clear: high to receive, low to transmit, high after stop.
`timescale 1ns/10ps
module dmp_modem_pins
   import dmp_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESETN,
   input  wire logic [3:0]  ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   output logic             IRQ,
   output logic             REQUEST_TO_SEND_B_N,
   input  wire logic        CLEAR_TO_SEND_B_N,
   output logic             TERMINAL_READY_B_N,
   input  wire logic        SET_READY_B_N,
   input  wire logic        CARRIER_DETECT_B_N,
   input  wire logic        RING_INDICATOR_B_N,
   output logic             MULTI_FUNCTION_OUT_B_N,
   input  wire logic        BAUD_16X,
   input  wire logic        RX_READY_DMA_B_N,
   input  wire logic        RX_FLOW_STOP,
   input  wire logic        TX_ACTIVE,
   output logic             TX_PERMIT
);

   // ==========================================================
   // Declarations.
   logic [7:0]       interrupt_enable_reg;
   logic [7:0]       alternate_function_reg;
   logic [7:0]       enhanced_feature_reg;
   logic [7:0]       modem_control_reg;
   logic [7:0]       feature_control_reg;
   logic [7:0]       extended_mode_select_reg;
   logic [3:0]       event_mask_reg;
   logic [3:0]       event_status_reg;
   logic [3:0]       event_status_next;
   logic [7:0]       rdata_reg;
   logic [7:0]       rdata_next;
   dmp_modem_in_type modem_now;
   dmp_modem_in_type modem_prev_reg;
   logic [3:0]       event_set;
   logic             auto_rts;
   logic             auto_cts;
   logic             dir_ctrl;
   logic             dir_invert;
   logic             req_send_active;
   logic             rts_pin_next;
   logic             rts_pin_reg;
   logic             dtr_pin_reg;
   logic             mf_pin_next;
   logic             mf_pin_reg;
   dmp_mf_sel_type   mf_sel;
   logic             status_read;

   assign auto_rts   = enhanced_feature_reg[EF_AUTO_RTS_BIT];
   assign auto_cts   = enhanced_feature_reg[EF_AUTO_CTS_BIT];
   assign dir_ctrl   = feature_control_reg[FC_DIR_CTRL_BIT];
   assign dir_invert = extended_mode_select_reg[EM_DIR_INVERT_BIT];

   // ==========================================================
   // Register writes. No write side effects beyond storage.
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         interrupt_enable_reg     <= REG_RESET;
         alternate_function_reg   <= REG_RESET;
         enhanced_feature_reg     <= REG_RESET;
         modem_control_reg        <= REG_RESET;
         feature_control_reg      <= REG_RESET;
         extended_mode_select_reg <= REG_RESET;
         event_mask_reg           <= EVT_RESET;
      end else if (WR) begin
         unique case (ADDR)
            OFS_INT_ENABLE:    interrupt_enable_reg     <= WDATA;
            OFS_ALT_FUNCTION:  alternate_function_reg   <= WDATA;
            OFS_ENH_FEATURE:   enhanced_feature_reg     <= WDATA;
            OFS_MODEM_CONTROL: modem_control_reg        <= WDATA;
            OFS_FEAT_CONTROL:  feature_control_reg      <= WDATA;
            OFS_EXT_MODE:      extended_mode_select_reg <= WDATA;
            OFS_EVENT_MASK:    event_mask_reg           <= WDATA[3:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Modem inputs, viewed active high. They feed status; clear-to-send also gates transmit.
   assign modem_now = '{cts: !CLEAR_TO_SEND_B_N, dsr: !SET_READY_B_N,
                        cd: !CARRIER_DETECT_B_N, ri: !RING_INDICATOR_B_N};

   // Previous levels, kept to see changes.
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         modem_prev_reg <= '0;
      end else begin
         modem_prev_reg <= modem_now;
      end
   end

   // A clear-to-send change only counts while its enable bit is set.
   always_comb begin
      event_set = modem_now ^ modem_prev_reg;
      event_set[3] = event_set[3] & interrupt_enable_reg[IE_CTS_BIT];
   end

   // ==========================================================
   // Sticky events; a read clears them but a new event wins.
   assign status_read = RD && (ADDR == OFS_EVENT_STATUS);

   always_comb begin
      event_status_next = status_read ? EVT_RESET : event_status_reg;
      event_status_next = event_status_next | event_set;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         event_status_reg <= EVT_RESET;
      end else begin
         event_status_reg <= event_status_next;
      end
   end

   // Level interrupt while any unmasked event is pending.
   assign IRQ = |(event_status_reg & event_mask_reg);

   // ==========================================================
   // Read port; data valid only in the cycle after the strobe.
   always_comb begin
      rdata_next = 8'h00;
      if (RD) begin
         unique case (ADDR)
            OFS_INT_ENABLE:    rdata_next = interrupt_enable_reg;
            OFS_ALT_FUNCTION:  rdata_next = alternate_function_reg;
            OFS_ENH_FEATURE:   rdata_next = enhanced_feature_reg;
            OFS_MODEM_CONTROL: rdata_next = modem_control_reg;
            OFS_FEAT_CONTROL:  rdata_next = feature_control_reg;
            OFS_EXT_MODE:      rdata_next = extended_mode_select_reg;
            OFS_MODEM_LEVELS:  rdata_next = {4'h0, modem_now};
            OFS_EVENT_STATUS:  rdata_next = {4'h0, event_status_reg};
            OFS_EVENT_MASK:    rdata_next = {4'h0, event_mask_reg};
            default:           rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign RDATA = rdata_reg;

   // ==========================================================
   // Request-to-send. Direction mode overrides flow control, so a
   // transceiver is never left enabled by a stale software bit.
   // Auto flow control only withdraws a request software has made.
   assign req_send_active = modem_control_reg[MC_REQ_SEND_BIT] &&
                            !(auto_rts && RX_FLOW_STOP);

   always_comb begin
      if (dir_ctrl) begin
         // Unless inverted, low while transmitting, high once the last stop bit is out.
         rts_pin_next = !TX_ACTIVE ^ dir_invert;
      end else begin
         rts_pin_next = !req_send_active;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rts_pin_reg <= 1'b1;
         dtr_pin_reg <= 1'b1;
      end else begin
         rts_pin_reg <= rts_pin_next;
         dtr_pin_reg <= !modem_control_reg[MC_TERM_READY_BIT];
      end
   end

   assign REQUEST_TO_SEND_B_N = rts_pin_reg;
   assign TERMINAL_READY_B_N  = dtr_pin_reg;

   // Clear-to-send gates the transmitter only under auto CTS.
   assign TX_PERMIT = !(auto_cts && modem_now.cts == 1'b0);

   // ==========================================================
   // Multi-function pin. The unused field code falls back to the
   // user output so the pin always has a defined meaning.
   always_comb begin
      unique case (alternate_function_reg[AF_SEL_MSB:AF_SEL_LSB])
         AF_CODE_BAUD:  mf_sel = MF_BAUD;
         AF_CODE_RXRDY: mf_sel = MF_RXRDY;
         default:       mf_sel = MF_USER;
      endcase
   end

   // The baud clock passes one flop, so it lags by one clock.
   always_comb begin
      unique case (mf_sel)
         MF_USER:  mf_pin_next =
                      !modem_control_reg[MC_USER_OUT2_BIT];
         MF_BAUD:  mf_pin_next = BAUD_16X;
         MF_RXRDY: mf_pin_next = RX_READY_DMA_B_N;
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         mf_pin_reg <= 1'b1;
      end else begin
         mf_pin_reg <= mf_pin_next;
      end
   end

   assign MULTI_FUNCTION_OUT_B_N = mf_pin_reg;

   // ==========================================================
   // Assertions.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   property p_rts_manual;
      (!dir_ctrl && !auto_rts) |=>
         (REQUEST_TO_SEND_B_N == !$past(modem_control_reg[1]));
   endproperty
   a_rts_manual: assert property (p_rts_manual)
      else $error("request-to-send does not follow control bit");

   property p_auto_rts_stop;
      (!dir_ctrl && auto_rts && RX_FLOW_STOP) |=> REQUEST_TO_SEND_B_N;
   endproperty
   a_auto_rts_stop: assert property (p_auto_rts_stop)
      else $error("auto flow control did not withdraw request");

   property p_cts_gate;
      (auto_cts && CLEAR_TO_SEND_B_N) |-> !TX_PERMIT;
   endproperty
   a_cts_gate: assert property (p_cts_gate)
      else $error("transmit permitted with clear-to-send high");

   property p_dir_tx;
      (dir_ctrl && !dir_invert && TX_ACTIVE) |=> !REQUEST_TO_SEND_B_N;
   endproperty
   a_dir_tx: assert property (p_dir_tx)
      else $error("direction pin not low while transmitting");

   property p_dir_idle;
      (dir_ctrl && !dir_invert && $fell(TX_ACTIVE)) |=>
         REQUEST_TO_SEND_B_N;
   endproperty
   a_dir_idle: assert property (p_dir_idle)
      else $error("direction pin not back high after transmit");

   // Inverted polarity suits transceivers with an active-high enable.
   property p_dir_invert;
      (dir_ctrl && dir_invert && !TX_ACTIVE) |=> !REQUEST_TO_SEND_B_N;
   endproperty
   a_dir_invert: assert property (p_dir_invert)
      else $error("inverted direction pin not low at idle");

   property p_dtr;
      1'b1 |=> (TERMINAL_READY_B_N == !$past(modem_control_reg[0]));
   endproperty
   a_dtr: assert property (p_dtr)
      else $error("terminal-ready does not follow control bit");

   property p_inputs_inert;
      !auto_cts |-> TX_PERMIT;
   endproperty
   a_inputs_inert: assert property (p_inputs_inert)
      else $error("modem inputs gated transmit without auto CTS");

   property p_mf_user_low;
      (mf_sel == MF_USER && modem_control_reg[3]) |=>
         !MULTI_FUNCTION_OUT_B_N;
   endproperty
   a_mf_user_low: assert property (p_mf_user_low)
      else $error("user output pin not low with bit set");

   property p_mf_user_high;
      (mf_sel == MF_USER && !modem_control_reg[3]) |=>
         MULTI_FUNCTION_OUT_B_N;
   endproperty
   a_mf_user_high: assert property (p_mf_user_high)
      else $error("user output pin not high with bit clear");

   property p_mf_baud;
      (alternate_function_reg[AF_SEL_MSB:AF_SEL_LSB] == AF_CODE_BAUD) |=>
         (MULTI_FUNCTION_OUT_B_N == $past(BAUD_16X));
   endproperty
   a_mf_baud: assert property (p_mf_baud)
      else $error("baud clock not on multi-function pin");

   property p_mf_rxrdy;
      (alternate_function_reg[AF_SEL_MSB:AF_SEL_LSB] == AF_CODE_RXRDY) |=>
         (MULTI_FUNCTION_OUT_B_N == $past(RX_READY_DMA_B_N));
   endproperty
   a_mf_rxrdy: assert property (p_mf_rxrdy)
      else $error("receive-ready not on multi-function pin");

   property p_reset_bit3;
      $rose(RESETN) |-> !modem_control_reg[3];
   endproperty
   a_reset_bit3: assert property (p_reset_bit3)
      else $error("control bit 3 not clear after reset");

   // While nothing clears or masks it, a pending event keeps the line up.
   property p_irq;
      (|(event_status_reg & event_mask_reg) && !status_read &&
       !(WR && ADDR == OFS_EVENT_MASK)) |=> IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt dropped with unmasked event pending");

   // An event that meets a status read in one cycle is still kept.
   property p_event_sticky;
      (|event_set) |=>
         ((event_status_reg & $past(event_set)) == $past(event_set));
   endproperty
   a_event_sticky: assert property (p_event_sticky)
      else $error("event lost from status register");

   // Without its enable bit a clear-to-send change must not be logged.
   property p_cts_event_gate;
      (!interrupt_enable_reg[IE_CTS_BIT] && !event_status_reg[3]) |=>
         !event_status_reg[3];
   endproperty
   a_cts_event_gate: assert property (p_cts_event_gate)
      else $error("clear-to-send event logged while disabled");

   cover_dir: cover property (dir_ctrl && $rose(TX_ACTIVE) ##1
                              !REQUEST_TO_SEND_B_N);
   cover_cts_block: cover property (auto_cts && !TX_PERMIT);
   cover_irq: cover property ($rose(IRQ));
   cover_baud: cover property (mf_sel == MF_BAUD && $rose(BAUD_16X));
   cover_read_clear: cover property (status_read && |event_status_reg);

endmodule : dmp_modem_pins

/* verification/dmp_modem_model.sv */
// Behavioural modem and baud source on the far side of the channel B pins.
`timescale 1ns/10ps
module dmp_modem_model (
   input  wire logic       CLK,
   input  wire logic       RESETN,
   input  wire logic [3:0] LINES_ON,
   output logic            CLEAR_TO_SEND_B_N,
   output logic            SET_READY_B_N,
   output logic            CARRIER_DETECT_B_N,
   output logic            RING_INDICATOR_B_N,
   output logic            BAUD_16X
);
   // ==========================================================
   // Modem lines.
   // Lines are driven active low; order on LINES_ON is cts,dsr,cd,ri.
   assign CLEAR_TO_SEND_B_N  = ~LINES_ON[3];
   assign SET_READY_B_N      = ~LINES_ON[2];
   assign CARRIER_DETECT_B_N = ~LINES_ON[1];
   assign RING_INDICATOR_B_N = ~LINES_ON[0];

   // ==========================================================
   // Baud clock.
   // A divide by four keeps the clock slow enough to check each phase.
   logic [1:0] div_reg;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end
   assign BAUD_16X = div_reg[1];
endmodule : dmp_modem_model

/* verification/dmp_modem_pins_tb.sv */
// Self-checking bench for the channel B modem pin block.
`timescale 1ns/10ps
module dmp_modem_pins_tb;
   import dmp_pkg::*;
   logic       clk, resetn, wr, rd, irq, rts_n, dtr_n, mf_n, permit;
   logic [3:0] addr, lines;
   logic [7:0] wdata, rdata, d;
   logic       cts_n, dsr_n, cd_n, ri_n, baud, rxr_n, flow_stop, tx_act;
   int         err_total, tests_run;

   dmp_modem_model modem (.CLK(clk), .RESETN(resetn), .LINES_ON(lines),
      .CLEAR_TO_SEND_B_N(cts_n), .SET_READY_B_N(dsr_n),
      .CARRIER_DETECT_B_N(cd_n), .RING_INDICATOR_B_N(ri_n),
      .BAUD_16X(baud));

   dmp_modem_pins dut (.CLK(clk), .RESETN(resetn), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
      .REQUEST_TO_SEND_B_N(rts_n), .CLEAR_TO_SEND_B_N(cts_n),
      .TERMINAL_READY_B_N(dtr_n), .SET_READY_B_N(dsr_n),
      .CARRIER_DETECT_B_N(cd_n), .RING_INDICATOR_B_N(ri_n),
      .MULTI_FUNCTION_OUT_B_N(mf_n), .BAUD_16X(baud),
      .RX_READY_DMA_B_N(rxr_n), .RX_FLOW_STOP(flow_stop),
      .TX_ACTIVE(tx_act), .TX_PERMIT(permit));

   // ==========================================================
   // Clock and watchdog.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // A hung sequence counts as a mismatch and still reaches the verdict.
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      close_out();
   end

   // ==========================================================
   // Shared tasks.
   task automatic close_out();
      if (err_total == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h", $time, what, got);
      end
   endtask : chk

   // Settles one or more edges so registered pins can be sampled.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : bus_wr

   // Read data stands only in the cycle after the strobe.
   task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      v = rdata;
   endtask : bus_rd

   // ==========================================================
   // Main sequence.
   initial begin
      err_total = 0;
      tests_run = 0;
      resetn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
      lines = 4'h0; rxr_n = 1'b1; flow_stop = 1'b0; tx_act = 1'b0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      tick(1);
      chk({5'h00, rts_n, dtr_n, mf_n}, 8'h07, "idle pins");
      chk({7'h00, permit}, 8'h01, "permit");
      bus_rd(OFS_MODEM_CONTROL, d);
      chk(d, 8'h00, "control reset");
      bus_rd(4'hF, d);
      chk(d, 8'h00, "unmapped");
      bus_wr(OFS_MODEM_CONTROL, 8'h0B);
      tick(1);
      chk({5'h00, rts_n, dtr_n, mf_n}, 8'h00, "pins on");
      // Auto flow control is enabled only after the pin is asserted.
      @(posedge clk);
      flow_stop <= 1'b1;
      bus_wr(OFS_ENH_FEATURE, 8'h40);
      tick(1);
      chk({7'h00, rts_n}, 8'h01, "auto rts stop");
      @(posedge clk);
      flow_stop <= 1'b0;
      tick(1);
      chk({7'h00, rts_n}, 8'h00, "auto rts go");
      bus_wr(OFS_FEAT_CONTROL, 8'h08);
      tick(1);
      chk({7'h00, rts_n}, 8'h01, "dir receive");
      @(posedge clk);
      tx_act <= 1'b1;
      tick(1);
      chk({7'h00, rts_n}, 8'h00, "dir transmit");
      @(posedge clk);
      tx_act <= 1'b0;
      tick(1);
      chk({7'h00, rts_n}, 8'h01, "dir after stop");
      bus_wr(OFS_EXT_MODE, 8'h08);
      tick(1);
      chk({7'h00, rts_n}, 8'h00, "dir inverted idle");
      bus_wr(OFS_EXT_MODE, 8'h00);
      bus_wr(OFS_FEAT_CONTROL, 8'h00);
      bus_wr(OFS_MODEM_CONTROL, 8'h03);
      tick(1);
      chk({7'h00, mf_n}, 8'h01, "user out off");
      bus_wr(OFS_ALT_FUNCTION, {5'h00, AF_CODE_BAUD, 1'b0});
      tick(1);
      for (int i = 0; i < 8; i++) begin
         d[0] = baud;
         tick(1);
         chk({7'h00, mf_n}, {7'h00, d[0]}, "baud out");
      end
      bus_wr(OFS_ALT_FUNCTION, {5'h00, AF_CODE_RXRDY, 1'b0});
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rxr_n <= i[0];
         tick(1);
         chk({7'h00, mf_n}, {7'h00, i[0]}, "rx ready out");
      end
      // The spare field code falls back to the user output.
      bus_wr(OFS_ALT_FUNCTION, 8'h06);
      bus_wr(OFS_MODEM_CONTROL, 8'h08);
      tick(1);
      chk({6'h00, dtr_n, mf_n}, 8'h02, "spare code user");
      bus_wr(OFS_MODEM_CONTROL, 8'h03);
      bus_wr(OFS_ALT_FUNCTION, {5'h00, AF_CODE_USER, 1'b0});
      // Without its enable bit a clear-to-send change logs nothing.
      @(posedge clk);
      lines <= 4'h8;
      tick(1);
      @(posedge clk);
      lines <= 4'h0;
      bus_rd(OFS_EVENT_STATUS, d);
      chk(d, 8'h00, "cts event gated");
      // Clear-to-send event, masking, read-clear and transmit gating.
      bus_wr(OFS_INT_ENABLE, 8'h80);
      bus_wr(OFS_EVENT_MASK, 8'h08);
      bus_wr(OFS_ENH_FEATURE, 8'h80);
      @(posedge clk);
      lines <= 4'h8;
      tick(1);
      chk({6'h00, irq, permit}, 8'h03, "cts on");
      bus_wr(OFS_EVENT_MASK, 8'h00);
      #1;
      chk({7'h00, irq}, 8'h00, "masked");
      bus_wr(OFS_EVENT_MASK, 8'h08);
      bus_rd(OFS_EVENT_STATUS, d);
      chk(d, 8'h08, "status");
      chk({7'h00, irq}, 8'h00, "irq cleared");
      @(posedge clk);
      lines <= 4'h0;
      tick(1);
      chk({7'h00, permit}, 8'h00, "cts off gates");
      @(posedge clk);
      lines <= 4'h7;
      tick(2);
      chk({6'h00, permit, mf_n}, 8'h01, "inputs inert");
      bus_rd(OFS_EVENT_STATUS, d);
      chk(d, 8'h0F, "events logged");
      bus_rd(OFS_MODEM_LEVELS, d);
      chk(d, 8'h07, "levels");
      close_out();
   end
endmodule : dmp_modem_pins_tb
